// ### rtl/interrupt_and_event_transfer_ctrl.sv
// interrupt and event transfer controller: arbitration, vectoring, 8 move channels
// assumes peripheral requests are one-cycle pulses on core_clk_in,
// fast inputs are asynchronous pins, memory answers a read one cycle later
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "iectrl_defs.svh"

module interrupt_and_event_transfer_ctrl
  import iectrl_pkg::*;
(
  // clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        ce_in,
  // request sources
  input  wire logic [19:0] periph_req_in,
  input  wire logic [3:0]  ext_pin_in,
  // cpu side
  input  wire logic [3:0]  running_level_in,
  input  wire logic        cpu_ack_in,
  input  wire logic        jump_cache_hit_in,
  output logic             irq_req_out,
  output logic [15:0]      irq_vector_out,
  output logic [3:0]       irq_level_out,
  output logic             branch_go_out,
  output logic             steal_out,
  // memory port for transfers
  input  wire logic [15:0] mem_rdata_in,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic             mem_byte_out,
  output logic [15:0]      mem_addr_out,
  output logic [15:0]      mem_wdata_out,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [15:0]      reg_rdata_out,
  // block interrupt
  output logic             irq_out
);

  // ==================== storage
  logic [3:0]  prio_reg  [`NODE_NUM];  // priority level per node
  logic        en_reg    [`NODE_NUM];  // node enable
  logic        route_reg [`NODE_NUM];  // 1: served by a transfer channel
  logic [2:0]  chsel_reg [`NODE_NUM];  // channel of the node
  logic [`NODE_NUM-1:0] req_reg;       // node_request_bit flags
  logic [15:0] src_reg   [`CHAN_NUM];  // source pointers
  logic [15:0] dst_reg   [`CHAN_NUM];  // destination pointers
  logic [7:0]  cnt_reg   [`CHAN_NUM];  // transfer counters
  logic [3:0]  cctl_reg  [`CHAN_NUM];  // channel control
  logic [3:0]  stat_reg;               // sticky event status
  logic [3:0]  mask_reg;               // event mask
  logic [7:0]  edge_reg;               // two select bits per fast input
  logic        sw_pend_reg;            // software trap waiting
  logic [7:0]  sw_num_reg;             // its trap number
  seq_state_type state_reg;            // sequencer
  logic [4:0]  node_reg;               // node in service
  logic        grant_sw_reg;           // service came from a trap
  logic [3:0]  lat_reg;                // latency down-counter
  logic [3:0]  ext_s1_reg;             // sync stage one
  logic [3:0]  ext_s2_reg;             // sync stage two
  logic [3:0]  ext_s3_reg;             // previous level for edges

  // ==================== decode
  logic        wr_node;                // write to a node register
  logic        wr_ch;                  // write to a channel register
  logic [2:0]  cur_ch;                 // channel of node in service
  logic [3:0]  ext_edge;               // detected fast-input edges
  logic        xfer_done;              // destination write issued
  logic        zero_hit;               // counter goes to zero now
  logic [3:0]  evt_set;                // status events this cycle

  assign wr_node = reg_wr_in && (reg_addr_in <= `OFS_NODE_LAST);
  assign wr_ch   = reg_wr_in && (reg_addr_in >= `OFS_CH_BASE)
                   && (reg_addr_in <= `OFS_CH_LAST);
  assign cur_ch  = chsel_reg[node_reg];
  assign xfer_done = (state_reg == ST_XDAT);
  assign zero_hit  = xfer_done && !cctl_reg[cur_ch][`CC_CONT]
                     && (cnt_reg[cur_ch] == 8'h01);

  // ==================== fast inputs: sync then edge select
  // only the second and third stages feed the edge detector
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ext_s1_reg <= 4'h0;
      ext_s2_reg <= 4'h0;
      ext_s3_reg <= 4'h0;
    end
    else if (ce_in)
    begin
      ext_s1_reg <= ext_pin_in;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // per input: bit0 rising, bit1 falling, both set catches either
  always_comb
  begin
    for (int e = 0; e < `EXT_NUM; e++)
    begin
      ext_edge[e] = (edge_reg[2*e]   &&  ext_s2_reg[e] && !ext_s3_reg[e])   // R15
                 || (edge_reg[2*e+1] && !ext_s2_reg[e] &&  ext_s3_reg[e]);
    end
  end

  // ==================== arbitration
  // ascending scan with strict compare keeps lowest index on ties
  logic        std_hit;                // a standard candidate exists
  logic [4:0]  std_node;               // its node
  logic [3:0]  std_prio;               // its level
  logic        xf_hit;                 // a transfer candidate exists
  logic [4:0]  xf_node;                // its node
  logic [3:0]  xf_prio;                // its level
  always_comb
  begin
    std_hit = 1'b0;
    std_node = 5'h00;
    std_prio = 4'h0;
    xf_hit = 1'b0;
    xf_node = 5'h00;
    xf_prio = 4'h0;
    for (int n = 0; n < `NODE_NUM; n++)
    begin
      if (req_reg[n] && en_reg[n])
      begin
        // exhausted channel falls back to a normal interrupt
        if (route_reg[n] && (cctl_reg[chsel_reg[n]][`CC_CONT]               // R02
            || cnt_reg[chsel_reg[n]] != 8'h00))
        begin
          if (!xf_hit || prio_reg[n] > xf_prio)                             // R18
          begin
            xf_hit = 1'b1;
            xf_node = 5'(n);
            xf_prio = prio_reg[n];
          end
        end
        else if (!std_hit || prio_reg[n] > std_prio)                        // R10
        begin
          std_hit = 1'b1;
          std_node = 5'(n);
          std_prio = prio_reg[n];
        end
      end
    end
  end

  logic xf_go;                         // start a transfer now
  logic std_go;                        // offer an interrupt now
  assign xf_go  = (state_reg == ST_IDLE) && xf_hit && (xf_prio > running_level_in);
  assign std_go = (state_reg == ST_IDLE) && !xf_go
                  && (sw_pend_reg || (std_hit && std_prio > running_level_in)); // R11

  // ==================== sequencer
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_reg <= ST_IDLE;
      node_reg <= 5'h00;
      grant_sw_reg <= 1'b0;
      lat_reg <= 4'h0;
      irq_req_out <= 1'b0;
      irq_vector_out <= 16'h0000;
      irq_level_out <= 4'h0;
      branch_go_out <= 1'b0;
      steal_out <= 1'b0;
    end
    else if (ce_in)
    begin
      branch_go_out <= 1'b0;
      steal_out <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (xf_go)
          begin
            node_reg <= xf_node;
            steal_out <= 1'b1;                                              // R04
            state_reg <= ST_XRD;
          end
          else if (std_go)
          begin
            // trap instruction is synchronous and goes first
            grant_sw_reg <= sw_pend_reg;
            node_reg <= std_node;
            irq_req_out <= 1'b1;
            irq_level_out <= sw_pend_reg ? running_level_in : std_prio;
            irq_vector_out <= sw_pend_reg ? {6'h00, sw_num_reg, 2'b00}      // R16
                            : {6'h00, `TRAP_BASE + 8'(std_node), 2'b00};    // R12
            state_reg <= ST_REQ;
          end
        end
        ST_REQ:
        begin
          if (cpu_ack_in)
          begin
            irq_req_out <= 1'b0;
            lat_reg <= (jump_cache_hit_in ? `LAT_HIT : `LAT_MISS) - 4'h1;   // R01
            state_reg <= ST_RESP;
          end
        end
        ST_RESP:
        begin
          // branch pulse lands 7 or 11 clocks after the accept
          if (lat_reg == 4'h1)
          begin
            branch_go_out <= 1'b1;                                          // R03
            state_reg <= ST_IDLE;
          end
          lat_reg <= lat_reg - 4'h1;
        end
        ST_XRD:  state_reg <= ST_XDAT;
        ST_XDAT: state_reg <= ST_XWR;
        ST_XWR:  state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==================== memory port of a transfer
  // read in the stolen cycle, write later while the cpu runs on
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_byte_out <= 1'b0;
      mem_addr_out <= 16'h0000;
      mem_wdata_out <= 16'h0000;
    end
    else if (ce_in)
    begin
      mem_rd_out <= xf_go;
      mem_wr_out <= xfer_done;
      if (xf_go)
      begin
        mem_addr_out <= src_reg[chsel_reg[xf_node]];
        mem_byte_out <= !cctl_reg[chsel_reg[xf_node]][`CC_WORD];            // R05
      end
      else if (xfer_done)
      begin
        mem_addr_out <= dst_reg[cur_ch];
        mem_wdata_out <= mem_rdata_in;
      end
    end
  end

  // ==================== channels
  genvar c;
  generate
    for (c = 0; c < `CHAN_NUM; c++)
    begin : g_chan
      logic [15:0] step;               // one byte or one word
      assign step = cctl_reg[c][`CC_WORD] ? 16'h0002 : 16'h0001;
      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          src_reg[c] <= 16'h0000;
          dst_reg[c] <= 16'h0000;
          cnt_reg[c] <= 8'h00;
          cctl_reg[c] <= 4'h0;
        end
        else if (ce_in)
        begin
          if (xfer_done && cur_ch == 3'(c))                                 // R08
          begin
            if (cctl_reg[c][`CC_INC_SRC])
              src_reg[c] <= src_reg[c] + step;                              // R05
            if (cctl_reg[c][`CC_INC_DST])
              dst_reg[c] <= dst_reg[c] + step;
            if (!cctl_reg[c][`CC_CONT])
              cnt_reg[c] <= cnt_reg[c] - 8'h01;                             // R06
          end
          else if (wr_ch && reg_addr_in[4:2] == 3'(c))
          begin
            case (reg_addr_in[1:0])
              2'h0:    src_reg[c] <= reg_wdata_in;
              2'h1:    dst_reg[c] <= reg_wdata_in;
              2'h2:    cnt_reg[c] <= reg_wdata_in[7:0];
              default: cctl_reg[c] <= reg_wdata_in[3:0];
            endcase
          end
        end
      end
    end
  endgenerate

  // ==================== nodes
  genvar n;
  generate
    for (n = 0; n < `NODE_NUM; n++)
    begin : g_node
      logic hw_set;                    // any source raises this node
      logic clr;                       // accept, transfer or software clear
      assign hw_set = periph_req_in[n]                                      // R13
                    || ((n < `EXT_NUM) ? ext_edge[n % `EXT_NUM] : 1'b0)
                    || (zero_hit && node_reg == 5'(n));                     // R07
      assign clr = (state_reg == ST_REQ && cpu_ack_in && !grant_sw_reg      // R19
                    && node_reg == 5'(n))
                 || (xfer_done && node_reg == 5'(n))
                 || (wr_node && reg_addr_in[4:0] == 5'(n) && !reg_wdata_in[`NC_REQ]);
      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          req_reg[n] <= 1'b0;
        else if (ce_in)
        begin
          // a set in the clearing cycle is kept
          if (hw_set || (wr_node && reg_addr_in[4:0] == 5'(n) && reg_wdata_in[`NC_REQ]))
            req_reg[n] <= 1'b1;                                             // R17
          else if (clr)
            req_reg[n] <= 1'b0;
        end
      end
      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          prio_reg[n] <= 4'h0;
          en_reg[n] <= 1'b0;
          route_reg[n] <= 1'b0;
          chsel_reg[n] <= 3'h0;
        end
        else if (ce_in && wr_node && reg_addr_in[4:0] == 5'(n))
        begin
          prio_reg[n] <= reg_wdata_in[`NC_PRIO_HI:0];                       // R09
          en_reg[n] <= reg_wdata_in[`NC_EN];
          route_reg[n] <= reg_wdata_in[`NC_ROUTE];
          chsel_reg[n] <= reg_wdata_in[`NC_CH_HI:`NC_CH_LO];
        end
      end
    end
  endgenerate

  // ==================== software trap, edge select, event status
  assign evt_set = {periph_req_in[`TIMER2_NODE] && req_reg[`TIMER2_NODE],   // R14
                    std_go && sw_pend_reg, zero_hit, xfer_done};
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sw_pend_reg <= 1'b0;
      sw_num_reg <= 8'h00;
      edge_reg <= 8'h00;
      mask_reg <= 4'h0;
      stat_reg <= 4'h0;
      irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (reg_wr_in && reg_addr_in == `OFS_SW_TRAP)
      begin
        sw_pend_reg <= 1'b1;
        sw_num_reg <= reg_wdata_in[7:0];
      end
      else if (std_go && sw_pend_reg)
        sw_pend_reg <= 1'b0;
      if (reg_wr_in && reg_addr_in == `OFS_EDGE_SEL)
        edge_reg <= reg_wdata_in[7:0];
      if (reg_wr_in && reg_addr_in == `OFS_EVT_MASK)
        mask_reg <= reg_wdata_in[3:0];
      // write one clears, a new event wins
      stat_reg <= (stat_reg & ~((reg_wr_in && reg_addr_in == `OFS_EVT_STAT)
                  ? reg_wdata_in[3:0] : 4'h0)) | evt_set;
      irq_out <= |(stat_reg & mask_reg);
    end
  end

  // ==================== read port, data one cycle after the strobe
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      reg_rdata_out <= 16'h0000;
    else if (ce_in)
    begin
      reg_rdata_out <= 16'h0000;       // unmapped reads give zero
      if (reg_rd_in)
      begin
        if (reg_addr_in <= `OFS_NODE_LAST)
          reg_rdata_out <= {4'h0, chsel_reg[reg_addr_in[4:0]],
                            route_reg[reg_addr_in[4:0]], req_reg[reg_addr_in[4:0]],
                            en_reg[reg_addr_in[4:0]], 2'b00, prio_reg[reg_addr_in[4:0]]};
        else if (reg_addr_in >= `OFS_CH_BASE && reg_addr_in <= `OFS_CH_LAST)
          case (reg_addr_in[1:0])
            2'h0:    reg_rdata_out <= src_reg[reg_addr_in[4:2]];
            2'h1:    reg_rdata_out <= dst_reg[reg_addr_in[4:2]];
            2'h2:    reg_rdata_out <= {8'h00, cnt_reg[reg_addr_in[4:2]]};
            default: reg_rdata_out <= {12'h000, cctl_reg[reg_addr_in[4:2]]};
          endcase
        else if (reg_addr_in == `OFS_EVT_STAT)
          reg_rdata_out <= {12'h000, stat_reg};
        else if (reg_addr_in == `OFS_EVT_MASK)
          reg_rdata_out <= {12'h000, mask_reg};
        else if (reg_addr_in == `OFS_EDGE_SEL)
          reg_rdata_out <= {8'h00, edge_reg};
        else if (reg_addr_in == `OFS_STATUS)
          reg_rdata_out <= {8'h00, sw_pend_reg, 4'h0, state_reg};
      end
    end
  end

  // ==================== checks
  a_branch_latency: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R01
    (ce_in && state_reg == ST_REQ && cpu_ack_in && jump_cache_hit_in)
      ##1 ce_in [*6] |=> branch_go_out)
    else $error("branch not 7 clocks after accept");
  a_steal_single: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R04
    steal_out && ce_in |=> !steal_out)
    else $error("transfer stole more than one cycle");
  a_steal_read: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R05
    steal_out |-> mem_rd_out && !irq_req_out)
    else $error("stolen cycle without source read");
  a_write_follows: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R05
    (steal_out && ce_in) ##1 ce_in |=> mem_wr_out)
    else $error("destination write missing");
  a_level_strict: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R11
    $rose(irq_req_out) && !$past(sw_pend_reg) |-> irq_level_out > $past(running_level_in))
    else $error("interrupt offered without higher level");
  a_vector_map: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R12
    $rose(irq_req_out) && !grant_sw_reg
      |-> irq_vector_out == {6'h00, `TRAP_BASE + 8'(node_reg), 2'b00})
    else $error("vector not four times trap number");
  a_req_clears: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R19
    (ce_in && xfer_done && !zero_hit && !periph_req_in[node_reg]) |=> !req_reg[node_reg])
    else $error("request flag kept after transfer");
  a_zero_raise: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R07
    (ce_in && zero_hit) |=> req_reg[node_reg] && cnt_reg[cur_ch] == 8'h00)
    else $error("zero count raised no interrupt");
  a_irq_level: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    ce_in |=> irq_out == |($past(stat_reg) & $past(mask_reg)))
    else $error("interrupt output mismatch");

endmodule // interrupt_and_event_transfer_ctrl

// ### include/iectrl_defs.svh
// constants of the interrupt and event transfer controller
// assumes one 50 MHz core clock and a plain strobe register port
//
// Overview of operation
// (R01) accepted interrupt branches after 7/11 clocks
// (R02) each node routes to interrupt or transfer
// (R03) standard service vectors cpu to node entry
// (R04) event transfer steals exactly one cpu cycle
// (R05) move byte/word, bump source/destination as configured
// (R06) count decrements per transfer, not when continuous
// (R07) count reaching zero raises the node's interrupt
// (R08) eight channels, own pointers and counters
// (R09) per-node register: request, enable, priority
// (R10) sixteen priority levels arbitrate pending requests; a transfer above the running level goes before any standard request
// (R11) preempt only for strictly higher priority
// (R12) vector equals trap number times four
// (R13) shared nodes: either source sets one flag
// (R14) timer2 node trap 20H, timers 3,4 follow
// (R15) fast inputs: rising, falling or both edges
// (R16) software trap vectors to its trap number
// (R17) software-set request bit interrupts like hardware
// (R18) equal priorities resolved by lowest node index; done among transfers and among standard requests, a transfer goes first
// (R19) request flag clears on accept or transfer
`ifndef IECTRL_DEFS_SVH
`define IECTRL_DEFS_SVH
// ==================== sizes
`define NODE_NUM     20
`define CHAN_NUM     8
`define EXT_NUM      4
`define TRAP_BASE    8'h10
`define TIMER2_NODE  5'h10
// ==================== register map (word index on the strobe port)
`define OFS_NODE_LAST 8'h13
`define OFS_CH_BASE   8'h20
`define OFS_CH_LAST   8'h3F
`define OFS_EVT_STAT  8'h40
`define OFS_EVT_MASK  8'h41
`define OFS_SW_TRAP   8'h42
`define OFS_EDGE_SEL  8'h43
`define OFS_STATUS    8'h44
// ==================== node control fields
`define NC_PRIO_HI   3
`define NC_EN        6
`define NC_REQ       7
`define NC_ROUTE     8
`define NC_CH_LO     9
`define NC_CH_HI     11
// ==================== channel control fields
`define CC_WORD      0
`define CC_INC_SRC   1
`define CC_INC_DST   2
`define CC_CONT      3
// ==================== event status bits
`define EV_DONE      0
`define EV_ZERO      1
`define EV_SWTRAP    2
`define EV_OVERRUN   3
// ==================== response latency in cpu clocks
`define LAT_HIT      4'h7
`define LAT_MISS     4'hB
`endif

// ### include/iectrl_pkg.sv
// types of the interrupt and event transfer controller
// assumes the constants header is included by the design file
package iectrl_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,  // arbitrating
    ST_REQ  = 3'b001,  // interrupt offered to cpu
    ST_RESP = 3'b010,  // response latency running
    ST_XRD  = 3'b011,  // stolen cycle, source read
    ST_XDAT = 3'b100,  // read data arriving
    ST_XWR  = 3'b101   // destination write
  } seq_state_type;
endpackage

// ### verif/xfer_memory_model.sv
// memory model on the transfer port of the event transfer controller
// assumes one core clock; reads answered in the cycle after the strobe
`timescale 1ns/1ps

module xfer_memory_model
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  // transfer port
  input  wire logic        mem_rd_in,
  input  wire logic [15:0] mem_addr_in,
  output logic      [15:0] mem_rdata_out
);
  // ====================
  // read data
  // ====================
  // data is a scramble of the address; outside the answer slot the
  // bus toggles, so a sample taken a cycle late never matches by luck
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      mem_rdata_out <= 16'hFFFF;
    else if (mem_rd_in)
      mem_rdata_out <= mem_addr_in ^ 16'h5A3C;
    else
      mem_rdata_out <= ~mem_rdata_out;
  end
endmodule // xfer_memory_model

// ### verif/interrupt_and_event_transfer_ctrl_bench.sv
// self-checking bench of the interrupt and event transfer controller
// assumes the memory model answers transfer reads; the bench plays the cpu
`timescale 1ns/1ps

module interrupt_and_event_transfer_ctrl_bench import iectrl_pkg::*;;
  // ====================
  // stimulus and observed signals
  // ====================
  logic        core_clk_in = 1'b0, resetn_in = 1'b0;
  logic        cpu_ack_in = 1'b0, jump_cache_hit_in = 1'b0, ce_in = 1'b1;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [19:0] periph_req_in = 20'h0;
  logic [3:0]  ext_pin_in = 4'h0, running_level_in = 4'h0, irq_level_out;
  logic [7:0]  reg_addr_in = 8'h0;
  logic [15:0] reg_wdata_in = 16'h0, mem_rdata_in, irq_vector_out;
  logic [15:0] mem_addr_out, mem_wdata_out, reg_rdata_out;
  logic        irq_req_out, branch_go_out, steal_out, irq_out;
  logic        mem_rd_out, mem_wr_out, mem_byte_out;
  int          fails = 0, checked = 0, cyc = 0;
  // one row: node, level, running level, cache hit, pulse source, offer
  typedef struct {logic [4:0] n; logic [3:0] l, r; logic h, p, g;} row_type;
  row_type     rows [5] = '{'{5'h00, 4'h1, 4'h0, 1'b1, 1'b1, 1'b1},
                            '{5'h10, 4'hF, 4'hE, 1'b0, 1'b1, 1'b1},
                            '{5'h11, 4'h4, 4'h4, 1'b1, 1'b0, 1'b0},
                            '{5'h12, 4'h2, 4'h0, 1'b0, 1'b0, 1'b1},
                            '{5'h13, 4'h8, 4'h9, 1'b1, 1'b0, 1'b0}};

  interrupt_and_event_transfer_ctrl u_dut (.core_clk_in, .resetn_in, .ce_in,
    .periph_req_in, .ext_pin_in, .running_level_in, .cpu_ack_in, .jump_cache_hit_in,
    .irq_req_out, .irq_vector_out, .irq_level_out, .branch_go_out, .steal_out,
    .mem_rdata_in, .mem_rd_out, .mem_wr_out, .mem_byte_out, .mem_addr_out,
    .mem_wdata_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .irq_out);
  xfer_memory_model u_mem (.core_clk_in, .resetn_in, .mem_rd_in(mem_rd_out),
    .mem_addr_in(mem_addr_out), .mem_rdata_out(mem_rdata_in));

  // ====================
  // shared tasks
  // ====================
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // register write: one strobe cycle, a gap before the next
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // register read: data stands only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input string what);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge core_clk_in);
    chk(what, e, reg_rdata_out);
  endtask
  task automatic pulse(input logic [4:0] n);
    @(posedge core_clk_in);
    periph_req_in <= 20'h1 << n;
    @(posedge core_clk_in);
    periph_req_in <= 20'h0;
  endtask
  // wait for an offer (or its absence), then ack and time the branch
  task automatic offer(input logic g, input logic [15:0] v, input logic [3:0] l,
                       input logic h);
    int n;
    n = 0;
    while (!(g && irq_req_out === 1'b1) && n < 12)
    begin
      @(posedge core_clk_in);
      n++;
    end
    chk("offer", {15'h0, g}, {15'h0, irq_req_out});
    if (g)
    begin
      chk("vector", v, irq_vector_out);
      chk("level", {12'h0, l}, {12'h0, irq_level_out});
      jump_cache_hit_in <= h;
      cpu_ack_in <= 1'b1;
      @(posedge core_clk_in);
      cpu_ack_in <= 1'b0;
      n = 0;
      do
      begin
        @(posedge core_clk_in);
        n++;
      end
      while (branch_go_out !== 1'b1 && n < 14);
      chk("latency", h ? 16'h7 : 16'hB, 16'(n));
    end
  endtask
  // one transfer on node 4: exactly one stolen cycle, then the write
  task automatic xfer(input logic [15:0] dst, input logic [15:0] dat, input logic b);
    int n, s;
    n = 0;
    s = 0;
    pulse(5'h04);
    while (mem_wr_out !== 1'b1 && n < 12)
    begin
      @(posedge core_clk_in);
      n++;
      s += (steal_out === 1'b1 && mem_rd_out === 1'b1);
    end
    chk("steals", 16'h1, 16'(s));
    chk("dest", dst, mem_addr_out);
    chk("byte", {15'h0, b}, {15'h0, mem_byte_out});
    if (!b)
      chk("data", dat, mem_wdata_out);
  endtask
  task automatic results();
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ====================
  // clock and hang guard
  // ====================
  initial
    forever #10 core_clk_in = ~core_clk_in;
  // whole run is near 350 cycles; the ceiling leaves wide margin
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      results();
    end
  end

  // ====================
  // main sequence
  // ====================
  initial
  begin
    repeat (10) @(posedge core_clk_in);
    chk("reset offer", 16'h0, {15'h0, irq_req_out});
    resetn_in <= 1'b1;
    // table: vectors, levels, strict preemption, software-set requests
    foreach (rows[i])
    begin
      running_level_in <= rows[i].r;
      wr({3'h0, rows[i].n}, {8'h0, 8'h40 | rows[i].l});
      if (rows[i].p)
        pulse(rows[i].n);
      else
        wr({3'h0, rows[i].n}, {8'h0, 8'hC0 | rows[i].l});
      offer(rows[i].g, (16'(rows[i].n) + 16'h10) << 2, rows[i].l, rows[i].h);
      rdchk({3'h0, rows[i].n}, {8'h0, 8'h40 | rows[i].l | (rows[i].g ? 8'h0 : 8'h80)},
            "node");
      wr({3'h0, rows[i].n}, {8'h0, 8'h40 | rows[i].l});
    end
    // priority order then fixed order among equals
    running_level_in <= 4'hF;
    wr(8'h03, 16'h00C9);
    wr(8'h05, 16'h00C9);
    wr(8'h07, 16'h00CC);
    running_level_in <= 4'h0;
    offer(1'b1, 16'h005C, 4'hC, 1'b1);
    offer(1'b1, 16'h004C, 4'h9, 1'b1);
    offer(1'b1, 16'h0054, 4'h9, 1'b0);
    wr(8'h42, 16'h002A);
    offer(1'b1, 16'h00A8, 4'h0, 1'b1);
    // channel 2: word moves, both pointers, count 2, then the interrupt
    wr(8'h28, 16'h1000);
    wr(8'h29, 16'h2000);
    wr(8'h2A, 16'h0002);
    wr(8'h2B, 16'h0007);
    wr(8'h04, 16'h0545);
    xfer(16'h2000, 16'h1000 ^ 16'h5A3C, 1'b0);
    xfer(16'h2002, 16'h1002 ^ 16'h5A3C, 1'b0);
    offer(1'b1, 16'h0050, 4'h5, 1'b0);
    rdchk(8'h2A, 16'h0000, "count");
    rdchk(8'h28, 16'h1004, "source");
    rdchk(8'h40, 16'h0007, "events");
    // events: masked, unmasked, cleared
    chk("irq masked", 16'h0, {15'h0, irq_out});
    wr(8'h41, 16'h0002);
    repeat (2) @(posedge core_clk_in);
    chk("irq raised", 16'h1, {15'h0, irq_out});
    wr(8'h40, 16'h0002);
    repeat (2) @(posedge core_clk_in);
    chk("irq cleared", 16'h0, {15'h0, irq_out});
    rdchk(8'h40, 16'h0005, "events");
    // continuous byte move: count kept, only source steps
    wr(8'h2B, 16'h000A);
    xfer(16'h2004, 16'h0, 1'b1);
    offer(1'b0, 16'h0, 4'h0, 1'b0);
    rdchk(8'h2A, 16'h0000, "count");
    rdchk(8'h28, 16'h1005, "source");
    // fast input shares node 0 with its peripheral, each edge selection
    wr(8'h00, 16'h0043);
    for (int m = 1; m < 4; m++)
    begin
      wr(8'h43, 16'(m));
      ext_pin_in <= 4'h1;
      offer(m[0], 16'h0040, 4'h3, 1'b1);
      ext_pin_in <= 4'h0;
      offer(m[1], 16'h0040, 4'h3, 1'b1);
    end
    // clock enable low: a register write is ignored
    ce_in <= 1'b0;
    wr(8'h41, 16'h0000);
    ce_in <= 1'b1;
    rdchk(8'h41, 16'h0002, "frozen mask");
    // reset in mid-run, then unmapped read
    resetn_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    rdchk(8'h00, 16'h0000, "node after reset");
    rdchk(8'hFF, 16'h0000, "unmapped");
    results();
  end
endmodule // interrupt_and_event_transfer_ctrl_bench
